// ==== hdl/dram_first_error_logger.sv ====
// first/next error logger for a two-channel memory controller
// assumes event pulses are one cycle wide and synchronous to mclk,
// and a classic wishbone master that holds its request until ack
//
// Our own choice: the Wishbone interface to the registers.

// Functional notes
// - first log catches only the first cycle's events
// - later events go to the next log
// - no new first flags while any set
// - flags survive the ordinary reset
// - writing one clears, zero keeps
// - same-cycle events all latch together
// - bits 15/7: memory test complete
// - bits 14/6: poisoned write, any ECC mode
// - bit 13: retry started on channel B
// - bit 12: sparing copy done, channel B
// - bit 11: error threshold reached, channel B
// - bit 10: scrubber uncorrectable error, channel B
// - bit 9: uncorrectable demand read or failed retry
// - bit 8: correctable error, also counted
// - bits 5..0: channel A counterparts
// - masked events neither logged nor counted
// - next log: same layout, write-one clear
module dram_first_error_logger (
    // clock, enable and resets
    input wire logic mclk,
    input wire logic ce,
    input wire logic sys_rst,
    input wire logic porRst,
    // wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatWr,
    output logic [31:0] wbDatRd,
    output logic wbAck,
    // controller events, index 0 is channel A, 1 is channel B
    input wire logic [1:0] testDone,
    input wire logic [1:0] poisonWrite,
    input wire logic [1:0] retryStart,
    input wire logic [1:0] copyDone,
    input wire logic [1:0] thresholdHit,
    input wire logic [1:0] scrubUncorr,
    input wire logic [1:0] readUncorr,
    input wire logic [1:0] retryFail,
    input wire logic [1:0] corrRead
);
    localparam int LW = mem_err_pkg::LOG_W;
    localparam int TN = mem_err_pkg::TYPE_N;
    localparam int BB = mem_err_pkg::CHAN_B_BASE;

    // expands byte selects into a bit mask
    function automatic logic [31:0] laneMask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // word address match, ignoring the two byte bits
    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    // bus state
    logic ack_reg;
    logic ack_next;
    logic [31:0] datRd_reg;
    logic [31:0] datRd_next;
    // software-written state
    logic [TN-1:0] mask_reg;
    logic [TN-1:0] mask_next;
    logic retryEn_reg;
    logic retryEn_next;

    // internal nets
    logic request;
    logic wrCommit;
    logic [31:0] wrBits;
    logic [LW-1:0] rawEvents;
    logic [LW-1:0] liveEvents;
    logic [LW-1:0] firstKept;
    logic firstEmpty;
    logic [31:0] rdData;
    logic [31:0] counts;
    logic [1:0] cntClr;
    logic [1:0] corrLive;

    log_if firstIf();
    log_if nextIf();

    // a request is live while cyc and stb are both high
    assign request = wbCyc & wbStb;
    // writes land at the edge where the master sees ack, not earlier,
    // so a held request can never clear twice
    assign wrCommit = ce & ack_reg & request & wbWe;
    assign wrBits = wbDatWr & laneMask(wbSel);

    // gather per-channel event pulses into the shared flag layout;
    // each input is taken as one pulse per event
    genvar ch;
    generate
        for (ch = 0; ch < mem_err_pkg::CHAN_N; ch++) begin : g_map
            localparam int B = ch * BB;
            assign rawEvents[B + mem_err_pkg::BIT_TEST_DONE] =
                testDone[ch];
            assign rawEvents[B + mem_err_pkg::BIT_POISON_WRITE] =
                poisonWrite[ch];
            assign rawEvents[B + mem_err_pkg::BIT_RETRY_START] =
                retryStart[ch];
            assign rawEvents[B + mem_err_pkg::BIT_COPY_DONE] =
                copyDone[ch];
            assign rawEvents[B + mem_err_pkg::BIT_THRESHOLD] =
                thresholdHit[ch];
            assign rawEvents[B + mem_err_pkg::BIT_SCRUB_UNCORR] =
                scrubUncorr[ch];
            // a failed retry only counts while retry is switched on
            assign rawEvents[B + mem_err_pkg::BIT_UNCORR_READ] =
                readUncorr[ch] | (retryFail[ch] & retryEn_reg);
            assign rawEvents[B + mem_err_pkg::BIT_CORR_READ] =
                corrRead[ch];
            assign corrLive[ch] =
                liveEvents[B + mem_err_pkg::BIT_CORR_READ];
        end
    endgenerate

    // one mask byte covers both channels
    assign liveEvents = rawEvents & ~{mask_reg, mask_reg};

    // first log: what is left after this cycle's clear decides whether
    // an arriving event is a first error or a next error
    assign firstIf.clrBits = (wrCommit & hit(wbAdr, mem_err_pkg::OFF_FIRST_LOG))
        ? wrBits[LW-1:0] : mem_err_pkg::LOG_RST;
    assign firstKept = firstIf.flags & ~firstIf.clrBits;
    assign firstEmpty = firstKept == mem_err_pkg::LOG_RST;
    // all events of the capturing cycle go in together
    assign firstIf.setBits = firstEmpty
        ? liveEvents : mem_err_pkg::LOG_RST;

    // next log takes everything the first log refused
    assign nextIf.clrBits = (wrCommit & hit(wbAdr, mem_err_pkg::OFF_NEXT_LOG))
        ? wrBits[LW-1:0] : mem_err_pkg::LOG_RST;
    assign nextIf.setBits = firstEmpty
        ? mem_err_pkg::LOG_RST : liveEvents;

    flag_log firstLog (
        .clk(mclk),
        .ce(ce),
        .porRst(porRst),
        .port(firstIf)
    );

    flag_log nextLog (
        .clk(mclk),
        .ce(ce),
        .porRst(porRst),
        .port(nextIf)
    );

    // count clears per channel half, by any one bit written in that half's byte lanes of a counter write
    assign cntClr[0] = wrCommit & hit(wbAdr, mem_err_pkg::OFF_SEC_COUNT)
        & (|wrBits[15:0]);
    assign cntClr[1] = wrCommit & hit(wbAdr, mem_err_pkg::OFF_SEC_COUNT)
        & (|wrBits[31:16]);

    sec_counter corrCount (
        .clk(mclk),
        .ce(ce),
        .porRst(porRst),
        .inc(corrLive),
        .clr(cntClr),
        .count(counts)
    );

    // read mux; unmapped words and reserved bits read as zero
    always_comb begin
        rdData = 32'h00000000;
        if (hit(wbAdr, mem_err_pkg::OFF_FIRST_LOG)) begin
            rdData[LW-1:0] = firstIf.flags;
        end else if (hit(wbAdr, mem_err_pkg::OFF_NEXT_LOG)) begin
            rdData[LW-1:0] = nextIf.flags;
        end else if (hit(wbAdr, mem_err_pkg::OFF_EVENT_MASK)) begin
            rdData[TN-1:0] = mask_reg;
        end else if (hit(wbAdr, mem_err_pkg::OFF_SEC_COUNT)) begin
            rdData = counts;
        end else if (hit(wbAdr, mem_err_pkg::OFF_CONTROL)) begin
            rdData[mem_err_pkg::BIT_RETRY_EN] = retryEn_reg;
        end
    end

    // bus handshake: ack one cycle after the request, dropped the next
    always_comb begin
        ack_next = ack_reg;
        datRd_next = datRd_reg;
        if (sys_rst) begin
            ack_next = 1'b0;
            datRd_next = 32'h00000000;
        end else if (ce) begin
            ack_next = request & ~ack_reg;
            if (request & ~ack_reg & ~wbWe) begin
                datRd_next = rdData;
            end
        end
    end

    always_ff @(posedge mclk) begin
        ack_reg <= ack_next;
        datRd_reg <= datRd_next;
    end

    // mask is sticky like the logs; retry enable follows sys_rst
    always_comb begin
        mask_next = mask_reg;
        retryEn_next = retryEn_reg;
        if (porRst) begin
            mask_next = mem_err_pkg::MASK_RST;
        end else if (wrCommit & hit(wbAdr, mem_err_pkg::OFF_EVENT_MASK)) begin
            // only the low byte lane carries mask bits
            mask_next = wbSel[0] ? wrBits[TN-1:0] : mask_reg;
        end
        if (sys_rst) begin
            retryEn_next = mem_err_pkg::CONTROL_RETRY_RST;
        end else if (wrCommit & hit(wbAdr, mem_err_pkg::OFF_CONTROL)
                     & wbSel[0]) begin
            retryEn_next = wbDatWr[mem_err_pkg::BIT_RETRY_EN];
        end
    end

    always_ff @(posedge mclk) begin
        mask_reg <= mask_next;
        retryEn_reg <= retryEn_next;
    end

    assign wbAck = ack_reg;
    assign wbDatRd = datRd_reg;
endmodule

// ==== hdl/flag_log.sv ====
// one sticky 16-bit log of write-one-to-clear flags
// assumes set and clear vectors are already qualified by the top
module flag_log (
    // clock, enable and power-on reset
    input wire logic clk,
    input wire logic ce,
    input wire logic porRst,
    // set, clear and state
    log_if.owner port
);
    logic [mem_err_pkg::LOG_W-1:0] flags_reg;
    logic [mem_err_pkg::LOG_W-1:0] flags_next;

    // set is ored after the clear so a new event is never lost
    always_comb begin
        flags_next = flags_reg;
        if (porRst) begin
            flags_next = mem_err_pkg::LOG_RST;
        end else if (ce) begin
            flags_next = (flags_reg & ~port.clrBits) | port.setBits;
        end
    end

    // only power-on reset touches these, so they survive sys_rst
    always_ff @(posedge clk) begin
        flags_reg <= flags_next;
    end

    assign port.flags = flags_reg;
endmodule

// ==== hdl/sec_counter.sv ====
// saturating per-channel counters of correctable read errors
// assumes one increment pulse per channel per cycle at most
module sec_counter (
    // clock, enable and power-on reset
    input wire logic clk,
    input wire logic ce,
    input wire logic porRst,
    // per-channel increment and clear
    input wire logic [mem_err_pkg::CHAN_N-1:0] inc,
    input wire logic [mem_err_pkg::CHAN_N-1:0] clr,
    // counts, channel b in the upper half
    output logic [mem_err_pkg::CHAN_N*mem_err_pkg::CNT_W-1:0] count
);
    localparam int W = mem_err_pkg::CNT_W;

    genvar ch;
    generate
        for (ch = 0; ch < mem_err_pkg::CHAN_N; ch++) begin : g_chan
            logic [W-1:0] cnt_reg;
            logic [W-1:0] cnt_next;

            // saturate rather than wrap so software never sees a small
            // count after a storm; a same-cycle clear applies first, then the increment
            always_comb begin
                cnt_next = cnt_reg;
                if (porRst) begin
                    cnt_next = mem_err_pkg::CNT_RST;
                end else if (ce) begin
                    if (clr[ch]) begin
                        cnt_next = mem_err_pkg::CNT_RST;
                    end
                    if (inc[ch] && cnt_next != mem_err_pkg::CNT_MAX) begin
                        cnt_next = cnt_next + 16'h0001;
                    end
                end
            end

            always_ff @(posedge clk) begin
                cnt_reg <= cnt_next;
            end

            assign count[ch*W +: W] = cnt_reg;
        end
    endgenerate
endmodule

// ==== pkg/log_if.sv ====
// carrier between the logger top and one sticky flag log
// assumes both ends run on the same clock
interface log_if;
    logic [15:0] setBits;
    logic [15:0] clrBits;
    logic [15:0] flags;
    modport owner(input setBits, input clrBits, output flags);
    modport user(output setBits, output clrBits, input flags);
endinterface

// ==== pkg/mem_err_pkg.sv ====
// constants shared by the memory error logger and its helpers
// assumes a 32-bit classic wishbone register bus with byte addresses
package mem_err_pkg;
    // layout widths
    localparam int LOG_W = 16;
    localparam int CHAN_N = 2;
    localparam int TYPE_N = 8;
    localparam int CNT_W = 16;

    // register byte offsets
    localparam logic [7:0] OFF_FIRST_LOG = 8'h80;
    localparam logic [7:0] OFF_NEXT_LOG = 8'h84;
    localparam logic [7:0] OFF_EVENT_MASK = 8'h88;
    localparam logic [7:0] OFF_SEC_COUNT = 8'h8c;
    localparam logic [7:0] OFF_CONTROL = 8'h90;

    // event positions inside one channel byte
    localparam int BIT_CORR_READ = 0;
    localparam int BIT_UNCORR_READ = 1;
    localparam int BIT_SCRUB_UNCORR = 2;
    localparam int BIT_THRESHOLD = 3;
    localparam int BIT_COPY_DONE = 4;
    localparam int BIT_RETRY_START = 5;
    localparam int BIT_POISON_WRITE = 6;
    localparam int BIT_TEST_DONE = 7;
    // channel b sits in the upper byte
    localparam int CHAN_B_BASE = 8;

    // control register fields
    localparam int BIT_RETRY_EN = 0;

    // reset values
    localparam logic [LOG_W-1:0] LOG_RST = 16'h0000;
    localparam logic [TYPE_N-1:0] MASK_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic CONTROL_RETRY_RST = 1'b1;
endpackage

// ==== verification/dram_first_error_logger_tb_top.sv ====
// self-checking bench for the first/next error logger
// assumes the model pulses events one cycle after go is raised
module dram_first_error_logger_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic ce, sys_rst, porRst, wbCyc, wbStb, wbWe, wbAck, go;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatWr, wbDatRd;
    logic [17:0] pat, evt;
    int err_total = 0;
    int checked = 0;
    // event type t of channel c sits on evt bit 2*t+c
    dram_first_error_logger uut (.mclk(mclk), .ce(ce), .sys_rst(sys_rst),
        .porRst(porRst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr),
        .wbDatRd(wbDatRd), .wbAck(wbAck), .corrRead(evt[1:0]),
        .readUncorr(evt[3:2]), .scrubUncorr(evt[5:4]),
        .thresholdHit(evt[7:6]), .copyDone(evt[9:8]),
        .retryStart(evt[11:10]), .poisonWrite(evt[13:12]),
        .testDone(evt[15:14]), .retryFail(evt[17:16]));
    mem_ctrl_model model (.mclk(mclk), .go(go), .pat(pat), .evt(evt));
    always #10 mclk = ~mclk;
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; waits for ack under a bound
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatWr <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            tally_and_finish();
        end
        q = wbDatRd;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic fire(input logic [17:0] p);
        @(posedge mclk);
        go <= 1'b1;
        pat <= p;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic pulse_rst(input logic por);
        @(posedge mclk);
        if (por) begin
            porRst <= 1'b1;
        end else begin
            sys_rst <= 1'b1;
        end
        repeat (2) @(posedge mclk);
        porRst <= 1'b0;
        sys_rst <= 1'b0;
    endtask
    task automatic t_types;
        for (int c = 0; c < 2; c++) begin
            for (int t = 0; t < 8; t++) begin
                fire(18'h1 << (2 * t + c));
                rdchk(8'h80, 32'h1 << (t + 8 * c));
                wr(8'h80, 32'h1 << (t + 8 * c));
                rdchk(8'h80, 32'h0);
            end
        end
        $display("event types done");
    endtask
    task automatic t_order;
        rdchk(8'h40, 32'h0);
        fire(18'h00001);
        fire(18'h00008);
        rdchk(8'h80, 32'h0001);
        rdchk(8'h84, 32'h0200);
        wr(8'h80, 32'h0);
        rdchk(8'h80, 32'h0001);
        wr(8'h84, 32'h0200);
        rdchk(8'h84, 32'h0);
        // the event lands at the very edge that clears the last flag
        fork
            wr(8'h80, 32'h0001);
            fire(18'h08000);
        join
        rdchk(8'h80, 32'h8000);
        rdchk(8'h84, 32'h0);
        wr(8'h80, 32'hffff);
        fire(18'h08001);
        rdchk(8'h80, 32'h8001);
        wr(8'h80, 32'hffff);
        $display("ordering done");
    endtask
    task automatic t_sticky;
        fire(18'h00020);
        pulse_rst(1'b0);
        rdchk(8'h80, 32'h0400);
        pulse_rst(1'b1);
        rdchk(8'h80, 32'h0);
        $display("sticky done");
    endtask
    task automatic t_mask;
        wr(8'h8c, 32'hffffffff);
        fire(18'h00002);
        rdchk(8'h8c, 32'h00010000);
        wr(8'h80, 32'hffff);
        wr(8'h88, 32'h01);
        rdchk(8'h88, 32'h01);
        fire(18'h00002);
        rdchk(8'h80, 32'h0);
        rdchk(8'h8c, 32'h00010000);
        wr(8'h88, 32'h0);
        fire(18'h20000);
        rdchk(8'h80, 32'h0200);
        wr(8'h80, 32'hffff);
        wr(8'h90, 32'h0);
        fire(18'h20000);
        rdchk(8'h80, 32'h0);
        wr(8'h90, 32'h1);
        $display("mask and retry done");
    endtask
    initial begin
        ce = 1'b1;
        sys_rst = 1'b1;
        porRst = 1'b1;
        {wbCyc, wbStb, wbWe, go} = 4'h0;
        wbAdr = 8'h00;
        wbSel = 4'hf;
        wbDatWr = 32'h0;
        pat = 18'h00000;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        porRst <= 1'b0;
        rdchk(8'h80, 32'h0);
        t_types();
        t_order();
        t_sticky();
        t_mask();
        tally_and_finish();
    end
endmodule

// ==== verification/mem_ctrl_model.sv ====
// stand-in for the controller error and event detection logic
// assumes the bench raises go for one cycle together with a pattern
module mem_ctrl_model (
    // clock
    input wire logic mclk,
    // request from the bench
    input wire logic go,
    input wire logic [17:0] pat,
    // event lines, two bits per type, channel a in the even bit
    output logic [17:0] evt
);
    timeunit 1ns;
    timeprecision 1ns;
    // lines fall after one cycle so no event is taken twice
    always_ff @(posedge mclk) begin
        evt <= go ? pat : 18'h00000;
    end
endmodule

// ==== verification/mem_err_logger_sva.sv ====
// bus and read-data checks for the first/next error logger
// assumes ce high while checked; sees only the top ports
module mem_err_logger_sva (
    // clock, enable and resets
    input wire logic mclk,
    input wire logic ce,
    input wire logic sys_rst,
    input wire logic porRst,
    // wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [31:0] wbDatRd,
    input wire logic wbAck
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ack answers a taken request one cycle later, for one cycle
    property p_ack_req;
        ce && wbCyc && wbStb && !wbAck |=> wbAck;
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack missing");
    property p_ack_pulse;
        ce && wbAck |=> !wbAck;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        wbAck |-> $past(wbCyc && wbStb && !wbAck);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    // the ordinary reset quiets the bus outputs
    property p_rst_out;
        @(posedge mclk) disable iff (porRst)
        sys_rst && ce |=> !wbAck && wbDatRd == 32'h0;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("bus after reset");
    // unmapped words read as zero
    property p_unmapped;
        wbAck && !wbWe && (wbAdr[7:2] < 6'h20 || wbAdr[7:2] > 6'h24)
        |-> wbDatRd == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
    // both logs are sixteen bits wide
    property p_log_hi;
        wbAck && !wbWe && (wbAdr[7:2] == 6'h20 || wbAdr[7:2] == 6'h21)
        |-> wbDatRd[31:16] == 16'h0;
    endproperty
    a_log_hi: assert property (p_log_hi) else $error("log width");
    property p_mask_hi;
        wbAck && !wbWe && wbAdr[7:2] == 6'h22 |-> wbDatRd[31:8] == 24'h0;
    endproperty
    a_mask_hi: assert property (p_mask_hi) else $error("mask width");
    // read data only moves with an answer or after reset
    property p_rd_hold;
        !$stable(wbDatRd) |-> wbAck || $past(sys_rst);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind dram_first_error_logger mem_err_logger_sva chk_i (.mclk(mclk),
    .ce(ce), .sys_rst(sys_rst), .porRst(porRst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbDatRd(wbDatRd),
    .wbAck(wbAck));
